// ### design/ppt_pkg.sv
// Constants and types for the port pins block with tone and divider.
// Assumes a CPU data-memory access port and option straps held static in operation.
package ppt_pkg;
  localparam logic [7:0] PPT_WIDE_ADDR = 8'h12;
  localparam logic [7:0] PPT_INPUT_ADDR = 8'h14;
  localparam logic [7:0] PPT_NARROW_ADDR = 8'h16;
  localparam logic [7:0] PPT_WIDE_RESET = 8'hff;
  localparam logic [3:0] PPT_NARROW_RESET = 4'hf;
  localparam logic [3:0] PPT_NARROW_UPPER = 4'h0;
  localparam int PPT_TONE0_BIT = 0;
  localparam int PPT_TONE1_BIT = 1;
  localparam int PPT_DIV_BIT = 3;
  localparam int PPT_FIXED_OD_LSB = 4;

  typedef struct packed {
    logic [7:0] wide_latch;
    logic [3:0] narrow_latch;
    logic [7:0] wide_pad_prev;
    logic div_level;
    logic wake_pulse;
  } ppt_state_s;
endpackage : ppt_pkg

// ### design/ppt_pin_if.sv
// Interface carrying one bidirectional port's pin signals between modules.
// Assumes the parent resolves pads from output enables.
`timescale 1ns/1ps
`default_nettype none
interface ppt_pin_if #(parameter int W = 8);
  logic [W-1:0] latch;
  logic [W-1:0] push_pull;
  logic [W-1:0] func_en;
  logic [W-1:0] func_val;
  logic [W-1:0] pad_o;
  logic [W-1:0] pad_oe;
  modport ctrl (output latch, output push_pull, output func_en, output func_val, input pad_o, input pad_oe);
  modport drv (input latch, input push_pull, input func_en, input func_val, output pad_o, output pad_oe);
endinterface : ppt_pin_if
`default_nettype wire

// ### design/ppt_pin_drv.sv
// Pad driver for one bidirectional port: push-pull or open-drain per line.
// Assumes pull-high resistors sit at the pad, outside this logic.
`timescale 1ns/1ps
`default_nettype none
module ppt_pin_drv #(
  parameter int W = 8
) (
  ppt_pin_if.drv pins
);
  logic [W-1:0] val;

  // Shared functions replace the latch value on their lines
  always_comb begin
    val = (pins.func_en & pins.func_val) | (~pins.func_en & pins.latch);
  end

  // Push-pull drives both levels; open-drain only pulls low
  assign pins.pad_o = val & pins.push_pull;
  assign pins.pad_oe = pins.push_pull | ~val;
endmodule : ppt_pin_drv
`default_nettype wire

// ### design/ppt_port_top.sv
// Top of the port pins block: wide and narrow bidirectional ports, input-only port,
// tone pair and divided-frequency output. Assumes a CPU data-memory strobe interface.
`timescale 1ns/1ps
`default_nettype none
module ppt_port_top
  import ppt_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  input wire logic [3:0] WIDE_PUSH_PULL_OPT_I,
  input wire logic [7:0] WIDE_WAKE_OPT_I,
  input wire logic [3:0] NARROW_PUSH_PULL_OPT_I,
  input wire logic TONE_OPT_I,
  input wire logic DIV_OPT_I,
  input wire logic DIV_SRC_OPT_I,
  input wire logic TONE_I,
  input wire logic OVERFLOW_ZERO_I,
  input wire logic OVERFLOW_ONE_I,
  input wire logic HALT_I,
  input wire logic [7:0] WIDE_PAD_I,
  output logic [7:0] WIDE_PAD_O,
  output logic [7:0] WIDE_PAD_OE_O,
  input wire logic [7:0] INPUT_PAD_I,
  input wire logic [3:0] NARROW_PAD_I,
  output logic [3:0] NARROW_PAD_O,
  output logic [3:0] NARROW_PAD_OE_O,
  output logic WAKE_O
);
  ppt_state_s state_reg;
  ppt_state_s state_next;
  ppt_pin_if #(.W(8)) wide_if ();
  ppt_pin_if #(.W(4)) narrow_if ();
  logic overflow_sel;
  logic [7:0] wide_pp;
  logic [7:0] wide_func_en;
  logic [7:0] wide_func_val;
  logic [7:0] wake_en;

  // Selected timer overflow for the divider
  assign overflow_sel = DIV_SRC_OPT_I ? OVERFLOW_ONE_I : OVERFLOW_ZERO_I;

  // Upper wide lines are fixed open-drain
  assign wide_pp = {4'h0, WIDE_PUSH_PULL_OPT_I};

  // Wake only on open-drain lines that are optioned in
  assign wake_en = WIDE_WAKE_OPT_I & ~wide_pp;

  // Shared function enables need push-pull structure
  always_comb begin
    wide_func_en = 8'h00;
    wide_func_val = 8'h00;
    if (TONE_OPT_I && wide_pp[PPT_TONE0_BIT] && wide_pp[PPT_TONE1_BIT]) begin
      wide_func_en[PPT_TONE0_BIT] = 1'b1;
      wide_func_en[PPT_TONE1_BIT] = 1'b1;
      // Tone pair steered by latch bits 1 and 0
      if (state_reg.wide_latch[PPT_TONE0_BIT]) begin
        wide_func_val[PPT_TONE0_BIT] = 1'b0;
        wide_func_val[PPT_TONE1_BIT] = 1'b0;
      end else if (state_reg.wide_latch[PPT_TONE1_BIT]) begin
        wide_func_val[PPT_TONE0_BIT] = TONE_I;
        wide_func_val[PPT_TONE1_BIT] = 1'b0;
      end else begin
        wide_func_val[PPT_TONE0_BIT] = TONE_I;
        wide_func_val[PPT_TONE1_BIT] = ~TONE_I;
      end
    end
    if (DIV_OPT_I && wide_pp[PPT_DIV_BIT]) begin
      wide_func_en[PPT_DIV_BIT] = 1'b1;
      // Latch bit 3 set forces the pad low
      wide_func_val[PPT_DIV_BIT] = ~state_reg.wide_latch[PPT_DIV_BIT] & state_reg.div_level;
    end
  end

  // Interface wiring to the pad drivers
  assign wide_if.latch = state_reg.wide_latch;
  assign wide_if.push_pull = wide_pp;
  assign wide_if.func_en = wide_func_en;
  assign wide_if.func_val = wide_func_val;
  assign narrow_if.latch = state_reg.narrow_latch;
  assign narrow_if.push_pull = NARROW_PUSH_PULL_OPT_I;
  assign narrow_if.func_en = 4'h0;
  assign narrow_if.func_val = 4'h0;

  ppt_pin_drv #(.W(8)) u_wide (
    .pins(wide_if)
  );

  ppt_pin_drv #(.W(4)) u_narrow (
    .pins(narrow_if)
  );

  assign WIDE_PAD_O = wide_if.pad_o;
  assign WIDE_PAD_OE_O = wide_if.pad_oe;
  assign NARROW_PAD_O = narrow_if.pad_o;
  assign NARROW_PAD_OE_O = narrow_if.pad_oe;
  assign WAKE_O = state_reg.wake_pulse;

  // Read path is pad levels, not latches; sampled live in the read cycle
  always_comb begin
    RDATA_O = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        PPT_WIDE_ADDR: RDATA_O = WIDE_PAD_I;
        PPT_INPUT_ADDR: RDATA_O = INPUT_PAD_I;
        PPT_NARROW_ADDR: RDATA_O = {PPT_NARROW_UPPER, NARROW_PAD_I};
        default: RDATA_O = 8'h00;
      endcase
    end
  end

  // Next state: latches, divider toggle, wake detection
  always_comb begin
    state_next = state_reg;
    state_next.wake_pulse = 1'b0;
    // Whole byte goes to the latch, so read-modify-write carries pad states in
    if (WR_I && ADDR_I == PPT_WIDE_ADDR) begin
      state_next.wide_latch = WDATA_I;
    end
    if (WR_I && ADDR_I == PPT_NARROW_ADDR) begin
      state_next.narrow_latch = WDATA_I[3:0];
    end
    // Writes to the input-only address are ignored on purpose
    if (overflow_sel) begin
      state_next.div_level = ~state_reg.div_level;
    end
    // Falling edges only count while halted
    if (HALT_I && |(wake_en & state_reg.wide_pad_prev & ~WIDE_PAD_I)) begin
      state_next.wake_pulse = 1'b1;
    end
    state_next.wide_pad_prev = WIDE_PAD_I;
  end

  // State register; latches reset to ones so lines float or pull high
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg.wide_latch <= PPT_WIDE_RESET;
      state_reg.narrow_latch <= PPT_NARROW_RESET;
      state_reg.wide_pad_prev <= PPT_WIDE_RESET;
      state_reg.div_level <= 1'b0;
      state_reg.wake_pulse <= 1'b0;
    end else if (CE_I) begin
      state_reg <= state_next;
    end
  end
endmodule : ppt_port_top
`default_nettype wire

// ### dv/ppt_checker.sv
// Assertions on the port pins top, from its ports.
// Assumes option straps and clock enable stay fixed.
`timescale 1ns/1ps
`default_nettype none
module ppt_checker (
  input wire logic CLK_I, RST_I, CE_I, WR_I, RD_I, HALT_I, WAKE_O,
  input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O, WIDE_WAKE_OPT_I, WIDE_PAD_I, INPUT_PAD_I, WIDE_PAD_O, WIDE_PAD_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // A taken wide write, and a falling wake edge; previous pad level matters
  sequence s_wide_wr; CE_I && WR_I && ADDR_I == 8'h12; endsequence
  sequence s_wake_fall; HALT_I && CE_I && |(WIDE_WAKE_OPT_I[7:4] & $past(WIDE_PAD_I[7:4]) & ~WIDE_PAD_I[7:4]); endsequence
  property p_rd_wide; RD_I && ADDR_I == 8'h12 |-> RDATA_O == WIDE_PAD_I; endproperty
  a_rd_wide: assert property (p_rd_wide) else $error("wide read");
  property p_rd_input; RD_I && ADDR_I == 8'h14 |-> RDATA_O == INPUT_PAD_I; endproperty
  a_rd_input: assert property (p_rd_input) else $error("input read");
  property p_unmapped; RD_I && ADDR_I[7:4] != 4'h1 |-> RDATA_O == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_wr; s_wide_wr |=> WIDE_PAD_OE_O[7:4] == ~$past(WDATA_I[7:4]); endproperty
  a_wr: assert property (p_wr) else $error("latch write");
  property p_hold; !(CE_I && WR_I && ADDR_I == 8'h12) |=> $stable(WIDE_PAD_OE_O[7:4]); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_od_low; WIDE_PAD_OE_O[7:4] != 4'h0 |-> (WIDE_PAD_O[7:4] & WIDE_PAD_OE_O[7:4]) == 4'h0; endproperty
  a_od_low: assert property (p_od_low) else $error("drove high");
  property p_wake; s_wake_fall |=> WAKE_O; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_no_wake; !HALT_I |=> !WAKE_O; endproperty
  a_no_wake: assert property (p_no_wake) else $error("stray wake");
endmodule : ppt_checker
bind ppt_port_top ppt_checker chk_u (.*);
`default_nettype wire

// ### dv/ppt_pads_model.sv
// Far-side pad model for one port.
// Released lines sit high unless pulled low.
`timescale 1ns/1ps
`default_nettype none
module ppt_pads_model #(parameter int W = 8) (
  input wire logic [W-1:0] pad_i, oe_i, low_i,
  output logic [W-1:0] lvl_o
);
  // A driving line wins; else pull-high or an external low
  assign lvl_o = (oe_i & pad_i) | (~oe_i & ~low_i);
endmodule : ppt_pads_model
`default_nettype wire

// ### dv/testbench.sv
// Bench for the port pins top: reads and writes.
// Assumes the pad models resolve the wide and narrow pins; INPUT_PAD_I is driven directly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLK_I = '0, RST_I = '1, CE_I = '1, WR_I = '0, RD_I = '0, HALT_I = '0, TONE_I = '0, v = '0, WAKE_O;
  logic TONE_OPT_I = '0, DIV_OPT_I = '0, DIV_SRC_OPT_I = '0, OVERFLOW_ZERO_I = '0, OVERFLOW_ONE_I = '0;
  logic [7:0] ADDR_I = '0, WDATA_I = '0, WIDE_WAKE_OPT_I = '0, INPUT_PAD_I = 8'ha5, wl = '0;
  logic [7:0] RDATA_O, WIDE_PAD_I, WIDE_PAD_O, WIDE_PAD_OE_O;
  logic [3:0] WIDE_PUSH_PULL_OPT_I = '0, NARROW_PUSH_PULL_OPT_I = '0, nl = '0;
  logic [3:0] NARROW_PAD_I, NARROW_PAD_O, NARROW_PAD_OE_O;
  int bad_count = 0, checks_done = 0, i;
  // Clock, 8 ns period
  always #4 CLK_I = ~CLK_I;
  ppt_port_top dut (.*);
  ppt_pads_model #(.W(8)) far_w (.pad_i(WIDE_PAD_O), .oe_i(WIDE_PAD_OE_O), .low_i(wl), .lvl_o(WIDE_PAD_I));
  ppt_pads_model #(.W(4)) far_n (.pad_i(NARROW_PAD_O), .oe_i(NARROW_PAD_OE_O), .low_i(nl), .lvl_o(NARROW_PAD_I));
  task chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask : chk
  // Strobes rise after a falling edge, so they span one rising edge
  task wr(input logic [7:0] a, d);
    @(negedge CLK_I) {ADDR_I, WDATA_I, WR_I} = {a, d, 1'h1};
    @(negedge CLK_I) WR_I = '0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    @(negedge CLK_I) {ADDR_I, RD_I} = {a, 1'h1};
    // Look just before the rising edge, so the latch update cannot race the compare
    #3 chk(RDATA_O, e);
    @(negedge CLK_I) RD_I = '0;
  endtask : rd
  task wr_rd(input logic [7:0] a, d, e);
    wr(a, d);
    rd(a, e);
  endtask : wr_rd
  task test_done;
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // Main sequence; wl and nl pull pads low from outside
  initial begin
    repeat (6) @(negedge CLK_I);
    RST_I = '0;
    rd(8'h12, 8'hff);
    wr_rd(8'h12, 8'h0f, 8'h0f);
    wl = 8'h02;
    rd(8'h12, 8'h0d);
    wl = '0;
    wr_rd(8'h12, 8'h8d, 8'h8d);
    wr_rd(8'h14, 8'h00, 8'ha5);
    CE_I = '0;
    wr(8'h12, 8'h00);
    CE_I = '1;
    rd(8'h12, 8'h8d);
    nl = 4'hf;
    wr_rd(8'h16, 8'h5a, 8'h00);
    NARROW_PUSH_PULL_OPT_I = 4'hf;
    rd(8'h16, 8'h0a);
    rd(8'h20, 8'h00);
    {WIDE_PUSH_PULL_OPT_I, TONE_OPT_I} = 5'h1f;
    for (i = 0; i < 8; i++) begin
      TONE_I = i[2];
      wr_rd(8'h12, {6'h0, i[1:0]}, {6'h0, i[0] ? 2'h0 : {!i[1] && !i[2], i[2]}});
    end
    {TONE_OPT_I, DIV_OPT_I} = 2'h1;
    // The other timer fires at i == 2 and must not toggle
    for (i = 0; i < 4; i++) begin
      @(negedge CLK_I) {OVERFLOW_ZERO_I, OVERFLOW_ONE_I} = {i != 2, i == 2};
      @(negedge CLK_I) {OVERFLOW_ZERO_I, OVERFLOW_ONE_I} = 2'h0;
      v = v ^ (i != 2);
      rd(8'h12, {4'h0, v, 3'h3});
    end
    wr_rd(8'h12, 8'h08, 8'h00);
    {HALT_I, WIDE_WAKE_OPT_I} = 9'h110;
    wr(8'h12, 8'hf0);
    // Let one edge see the released high level before pulling the line low
    @(negedge CLK_I);
    wl = 8'h10;
    for (i = 0; i < 4 && WAKE_O !== 1'h1; i++) @(negedge CLK_I);
    chk({7'h0, WAKE_O}, 8'h01);
    test_done;
  end
endmodule : testbench
`default_nettype wire
